// ==== src/adc_trig_pkg.sv ====
// Purpose: Shared constants of the converter trigger and sample-time block
// Assumes: 32-bit register bus, one aligned word per register
// Notes:   Offsets are byte addresses; control word offset is a local choice
package adc_trig_pkg;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFFSET     = 12'h008;
  localparam logic [11:0] SMP_HIGH_OFFSET = 12'h00c;
  localparam logic [11:0] SMP_LOW_OFFSET  = 12'h010;

  // Values after reset
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam logic [31:0] SMP_HIGH_RESET  = 32'h0000_0000;
  localparam logic [31:0] SMP_LOW_RESET   = 32'h0000_0000;

  // Implemented bits; all others read as zero
  localparam logic [31:0] SMP_HIGH_MASK   = 32'h00ff_ffff;
  localparam logic [31:0] SMP_LOW_MASK    = 32'h3fff_ffff;

  // Control field positions
  localparam int INJ_SEL_LSB     = 12;
  localparam int INJ_EXT_EN_BIT  = 15;
  localparam int REG_SEL_LSB     = 17;
  localparam int REG_EXT_EN_BIT  = 20;
  localparam int INJ_SW_BIT      = 21;
  localparam int REG_SW_BIT      = 22;
  localparam int SENSOR_EN_BIT   = 23;

  // Sample-time fields
  localparam int SMP_CODE_W      = 3;
  localparam int SMP_HIGH_W      = 24;
  localparam int SMP_LOW_W       = 30;
  localparam int SMP_CHANNELS    = 18;

  // Trigger code that picks the software start bit
  localparam logic [2:0] SW_START_CODE = 3'h7;

  // Sampling time per code, in half converter clock periods
  localparam logic [9:0] SMP_HALF_PERIODS [8] = '{
    10'h003, 10'h00f, 10'h01b, 10'h039, 10'h053, 10'h06f, 10'h08f, 10'h1df};

  // Position of each timer in the raw event vector; k: 0..3 compare 1..4, 4 trigger out
  localparam int TMR_EVENTS = 5;
  localparam int T1_BASE    = 0;
  localparam int T2_BASE    = 5;
  localparam int T3_BASE    = 10;
  localparam int T4_BASE    = 15;
  localparam int T5_BASE    = 20;
  localparam int T8_BASE    = 25;
  localparam int EXT11_BIT  = 30;
  localparam int EXT15_BIT  = 31;
  localparam int TIMER_TRIGGER_OUTPUT_K     = 4;

  // Bus transfer type with the address-phase bit
  localparam int HTRANS_ACTIVE_BIT = 1;

endpackage : adc_trig_pkg

// ==== src/trigger_mux.sv ====
// Purpose: Pick one of seven event sources or the software start bit
// Assumes: Sources already synchronised to hclk
// Notes:   Timer sources start on a rising edge, the software bit on its level
`timescale 1ns/10ps
module trigger_mux (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [6:0] source_level,
  input  wire logic       sw_start,
  input  wire logic [2:0] select,
  input  wire logic       enable,
  output logic            start
);

  typedef struct packed {
    logic [6:0] prev_level;
  } mux_state_t;

  mux_state_t state_reg;
  mux_state_t state_next;

  // Edge per source, so a change of selection to a source already high does not fire
  always_comb begin
    state_next            = state_reg;
    state_next.prev_level = source_level;
    start                 = 1'b0;
    if (enable) begin                                            // R18
      if (select == adc_trig_pkg::SW_START_CODE) begin
        start = sw_start;                                        // R5
      end else begin
        start = source_level[select] & ~state_reg.prev_level[select];  // R18
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  chk_start_needs_enable: assert property (  // R18
    @(posedge hclk) disable iff (!hresetn) start |-> enable)
    else $error("start without trigger enable");

endmodule : trigger_mux

// ==== src/sample_time_decode.sv ====
// Purpose: Turn a channel's sample-time code into a duration
// Assumes: Channel comes from converter logic on hclk
// Notes:   Result in half periods, one cycle after the channel is given
`timescale 1ns/10ps
module sample_time_decode (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [53:0] codes,
  input  wire logic [4:0]  channel,
  output logic [9:0]       half_periods
);

  typedef struct packed {
    logic [9:0] half_periods;
  } dec_state_t;

  dec_state_t state_reg;
  dec_state_t state_next;
  logic [2:0] code;

  // Channels above the last read as the shortest time
  always_comb begin
    state_next = state_reg;
    code       = 3'h0;
    if (int'(channel) < adc_trig_pkg::SMP_CHANNELS) begin
      code = codes[int'(channel) * adc_trig_pkg::SMP_CODE_W +: 3];
    end
    state_next.half_periods = adc_trig_pkg::SMP_HALF_PERIODS[code];  // R11
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign half_periods = state_reg.half_periods;

  chk_longest_code: assert property (  // R11
    @(posedge hclk) disable iff (!hresetn)
    (int'(channel) < adc_trig_pkg::SMP_CHANNELS && code == 3'h7)
    |=> half_periods == 10'h1df)
    else $error("code seven not 239.5 periods");

endmodule : sample_time_decode

// ==== src/adc_trigger_config.sv ====
// Purpose: Trigger selection, trigger enables and sample times of one converter
// Assumes: AHB-Lite slave with zero wait states; timer events are asynchronous
// Notes:   CONVERTER_INDEX picks the trigger source table and the sensor bit
//
// Contract
// R1: Converters one and two: regular codes 0-4 pick timer1/2/3 events, 7 software.
// R2: Converters one and two: code 5 timer4 compare four, code 6 line 11.
// R3: Converter three: regular codes pick timer3, 2, 1, 8, 5 events, 7 software.
// R4: Control bit 20 enables regular external triggering.
// R5: Control bit 21, selected by injected code 7, starts injected group.
// R6: Hardware clears bit 21 once the injected start is issued.
// R7: Control bit 22, selected by regular code 7, starts regular group.
// R8: Hardware clears bit 22 once the regular start is issued.
// R9: Control bit 23 enables internal sensor and reference channels.
// R10: Sensor enable exists only in converter one; elsewhere it reads zero.
// R11: Sample code maps to 1.5 up to 239.5 converter periods.
// R12: High-channel register holds channels 10-17, bits 31:24 reserved.
// R13: Low-channel register holds channels 0-9, bits 31:30 reserved.
// R14: Sample registers at 0x0c and 0x10, reset to zero.
// R15: Regular trigger select is control bits 19:17.
// R16: Injected trigger select is control bits 14:12; code 7 picks bit 21.
// R17: Control bit 15 enables injected external triggering.
// R18: A group starts on its selected event only while its enable is set.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/10ps
module adc_trigger_config #(
  parameter int CONVERTER_INDEX = 1
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [3:0]  timer1_compare_event,
  input  wire logic        timer1_trigger_output,
  input  wire logic [3:0]  timer2_compare_event,
  input  wire logic        timer2_trigger_output,
  input  wire logic [3:0]  timer3_compare_event,
  input  wire logic        timer3_trigger_output,
  input  wire logic [3:0]  timer4_compare_event,
  input  wire logic        timer4_trigger_output,
  input  wire logic [3:0]  timer5_compare_event,
  input  wire logic        timer5_trigger_output,
  input  wire logic [3:0]  timer8_compare_event,
  input  wire logic        timer8_trigger_output,
  input  wire logic        external_interrupt_line_11,
  input  wire logic        external_interrupt_line_15,
  input  wire logic [4:0]  sample_channel,
  output logic [9:0]       sample_half_periods,
  output logic             regular_start,
  output logic             injected_start,
  output logic             internal_sensor_channel_enable
);

  typedef enum logic [1:0] {
    REG_NONE,
    REG_CTRL,
    REG_SMP_HIGH,
    REG_SMP_LOW
  } reg_index_t;

  typedef struct packed {
    logic        dp_valid;
    logic        dp_write;
    reg_index_t  dp_index;
    logic [2:0]  injected_trigger_select;
    logic        injected_external_trigger_enable;
    logic [2:0]  regular_trigger_select;
    logic        regular_external_trigger_enable;
    logic        injected_software_start;
    logic        regular_software_start;
    logic        internal_sensor_channel_enable;
    logic [23:0] smp_high;
    logic [29:0] smp_low;
    logic [31:0] hrdata;
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic        regular_start;
    logic        injected_start;
  } cfg_state_t;

  cfg_state_t  state_reg;
  cfg_state_t  state_next;
  logic [31:0] event_raw;
  logic [31:0] ev;
  logic [6:0]  reg_src;
  logic [6:0]  inj_src;
  logic        reg_start_now;
  logic        inj_start_now;
  logic        addr_phase;
  reg_index_t  addr_index;
  logic        ctrl_wr_now;
  logic [31:0] ctrl_word;

  // Raw events, one word, in the order the package positions give
  assign event_raw = {external_interrupt_line_15, external_interrupt_line_11,
                      timer8_trigger_output, timer8_compare_event,
                      timer5_trigger_output, timer5_compare_event,
                      timer4_trigger_output, timer4_compare_event,
                      timer3_trigger_output, timer3_compare_event,
                      timer2_trigger_output, timer2_compare_event,
                      timer1_trigger_output, timer1_compare_event};
  assign ev = state_reg.sync2;

  // Source tables differ between the first pair and the third converter
  always_comb begin
    if (CONVERTER_INDEX == 3) begin
      reg_src = {ev[adc_trig_pkg::T5_BASE + 2], ev[adc_trig_pkg::T5_BASE],      // R3
                 ev[adc_trig_pkg::T8_BASE + adc_trig_pkg::TIMER_TRIGGER_OUTPUT_K],
                 ev[adc_trig_pkg::T8_BASE], ev[adc_trig_pkg::T1_BASE + 2],
                 ev[adc_trig_pkg::T2_BASE + 2], ev[adc_trig_pkg::T3_BASE]};
      inj_src = {ev[adc_trig_pkg::T5_BASE + 3],
                 ev[adc_trig_pkg::T5_BASE + adc_trig_pkg::TIMER_TRIGGER_OUTPUT_K],
                 ev[adc_trig_pkg::T8_BASE + 3], ev[adc_trig_pkg::T8_BASE + 1],
                 ev[adc_trig_pkg::T4_BASE + 2], ev[adc_trig_pkg::T1_BASE + 3],
                 ev[adc_trig_pkg::T1_BASE + adc_trig_pkg::TIMER_TRIGGER_OUTPUT_K]};
    end else begin
      reg_src = {ev[adc_trig_pkg::EXT11_BIT], ev[adc_trig_pkg::T4_BASE + 3],    // R2
                 ev[adc_trig_pkg::T3_BASE + adc_trig_pkg::TIMER_TRIGGER_OUTPUT_K],              // R1
                 ev[adc_trig_pkg::T2_BASE + 1], ev[adc_trig_pkg::T1_BASE + 2],
                 ev[adc_trig_pkg::T1_BASE + 1], ev[adc_trig_pkg::T1_BASE]};
      inj_src = {ev[adc_trig_pkg::EXT15_BIT],
                 ev[adc_trig_pkg::T4_BASE + adc_trig_pkg::TIMER_TRIGGER_OUTPUT_K],
                 ev[adc_trig_pkg::T3_BASE + 3], ev[adc_trig_pkg::T2_BASE],
                 1'b0, ev[adc_trig_pkg::T2_BASE + 3],                            // Code 2 unused
                 ev[adc_trig_pkg::T1_BASE + adc_trig_pkg::TIMER_TRIGGER_OUTPUT_K]};
    end
  end

  trigger_mux u_regular_mux (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .source_level (reg_src),
    .sw_start     (state_reg.regular_software_start),
    .select       (state_reg.regular_trigger_select),
    .enable       (state_reg.regular_external_trigger_enable),
    .start        (reg_start_now)
  );

  trigger_mux u_injected_mux (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .source_level (inj_src),
    .sw_start     (state_reg.injected_software_start),
    .select       (state_reg.injected_trigger_select),
    .enable       (state_reg.injected_external_trigger_enable),
    .start        (inj_start_now)
  );

  // Address decode of the bus address phase
  assign addr_phase = hsel & hready & htrans[adc_trig_pkg::HTRANS_ACTIVE_BIT];
  always_comb begin
    if (haddr[11:0] == adc_trig_pkg::CTRL_OFFSET) begin
      addr_index = REG_CTRL;
    end else if (haddr[11:0] == adc_trig_pkg::SMP_HIGH_OFFSET) begin
      addr_index = REG_SMP_HIGH;
    end else if (haddr[11:0] == adc_trig_pkg::SMP_LOW_OFFSET) begin
      addr_index = REG_SMP_LOW;
    end else begin
      addr_index = REG_NONE;                    // Unmapped: read zero, write dropped
    end
  end

  assign ctrl_wr_now = state_reg.dp_valid & state_reg.dp_write &
                       (state_reg.dp_index == REG_CTRL);

  // Next state: sync, hardware clears, bus write, then read data
  always_comb begin
    state_next = state_reg;
    ctrl_word  = '0;
    // First stage feeds only the second
    state_next.sync1 = event_raw;
    state_next.sync2 = state_reg.sync1;

    // Hardware clears the start bit once its start is issued
    if (reg_start_now) begin
      state_next.regular_software_start = 1'b0;                          // R8
    end
    if (inj_start_now) begin
      state_next.injected_software_start = 1'b0;                         // R6
    end

    // Software write in the data phase; a set wins over the hardware clear
    if (state_reg.dp_valid && state_reg.dp_write) begin
      if (state_reg.dp_index == REG_CTRL) begin
        state_next.injected_trigger_select =
          hwdata[adc_trig_pkg::INJ_SEL_LSB +: 3];                        // R16
        state_next.injected_external_trigger_enable =
          hwdata[adc_trig_pkg::INJ_EXT_EN_BIT];                          // R17
        state_next.regular_trigger_select =
          hwdata[adc_trig_pkg::REG_SEL_LSB +: 3];                        // R15
        state_next.regular_external_trigger_enable =
          hwdata[adc_trig_pkg::REG_EXT_EN_BIT];                          // R4
        state_next.injected_software_start = hwdata[adc_trig_pkg::INJ_SW_BIT];  // R5
        state_next.regular_software_start  = hwdata[adc_trig_pkg::REG_SW_BIT];  // R7
        state_next.internal_sensor_channel_enable =
          (CONVERTER_INDEX == 1) & hwdata[adc_trig_pkg::SENSOR_EN_BIT];  // R9 R10
      end else if (state_reg.dp_index == REG_SMP_HIGH) begin
        state_next.smp_high = hwdata[adc_trig_pkg::SMP_HIGH_W-1:0];      // R12
      end else if (state_reg.dp_index == REG_SMP_LOW) begin
        state_next.smp_low = hwdata[adc_trig_pkg::SMP_LOW_W-1:0];        // R13
      end
    end

    // Start pulses leave from flops
    state_next.regular_start  = reg_start_now;
    state_next.injected_start = inj_start_now;

    // Capture the new address phase
    state_next.dp_valid = addr_phase;
    state_next.dp_write = hwrite;
    state_next.dp_index = addr_index;

    // Read data from updated state, so a write just before is seen
    ctrl_word[adc_trig_pkg::INJ_SEL_LSB +: 3]    = state_next.injected_trigger_select;
    ctrl_word[adc_trig_pkg::INJ_EXT_EN_BIT]      =
      state_next.injected_external_trigger_enable;
    ctrl_word[adc_trig_pkg::REG_SEL_LSB +: 3]    = state_next.regular_trigger_select;
    ctrl_word[adc_trig_pkg::REG_EXT_EN_BIT]      =
      state_next.regular_external_trigger_enable;
    ctrl_word[adc_trig_pkg::INJ_SW_BIT]          = state_next.injected_software_start;
    ctrl_word[adc_trig_pkg::REG_SW_BIT]          = state_next.regular_software_start;
    ctrl_word[adc_trig_pkg::SENSOR_EN_BIT]       =
      state_next.internal_sensor_channel_enable;
    state_next.hrdata = '0;
    if (addr_phase && !hwrite) begin
      if (addr_index == REG_CTRL) begin
        state_next.hrdata = ctrl_word;
      end else if (addr_index == REG_SMP_HIGH) begin
        state_next.hrdata = {8'h00, state_next.smp_high};               // R12
      end else if (addr_index == REG_SMP_LOW) begin
        state_next.hrdata = {2'h0, state_next.smp_low};                 // R13
      end
    end
  end

  // Reset values: all fields zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg          <= '0;
      state_reg.smp_high <= adc_trig_pkg::SMP_HIGH_RESET[23:0];          // R14
      state_reg.smp_low  <= adc_trig_pkg::SMP_LOW_RESET[29:0];           // R14
    end else begin
      state_reg <= state_next;
    end
  end

  sample_time_decode u_sample_decode (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .codes        ({state_reg.smp_high, state_reg.smp_low}),
    .channel      (sample_channel),
    .half_periods (sample_half_periods)
  );

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = state_reg.hrdata;
  assign regular_start  = state_reg.regular_start;
  assign injected_start = state_reg.injected_start;
  assign internal_sensor_channel_enable = state_reg.internal_sensor_channel_enable;

  chk_reg_sw_starts: assert property (  // R7
    @(posedge hclk) disable iff (!hresetn)
    (state_reg.regular_trigger_select == 3'h7 && state_reg.regular_external_trigger_enable
     && state_reg.regular_software_start) |=> regular_start)
    else $error("regular software start ignored");

  chk_inj_sw_starts: assert property (  // R5
    @(posedge hclk) disable iff (!hresetn)
    (state_reg.injected_trigger_select == 3'h7 && state_reg.injected_external_trigger_enable
     && state_reg.injected_software_start) |=> injected_start)
    else $error("injected software start ignored");

  chk_reg_sw_clear: assert property (  // R8
    @(posedge hclk) disable iff (!hresetn)
    (reg_start_now && !ctrl_wr_now) |=> !state_reg.regular_software_start)
    else $error("regular start bit not cleared");

  chk_inj_sw_clear: assert property (  // R6
    @(posedge hclk) disable iff (!hresetn)
    (inj_start_now && !ctrl_wr_now) |=> !state_reg.injected_software_start)
    else $error("injected start bit not cleared");

  chk_reg_disabled: assert property (  // R4
    @(posedge hclk) disable iff (!hresetn)
    !state_reg.regular_external_trigger_enable |=> !regular_start)
    else $error("regular start while disabled");

  chk_inj_disabled: assert property (  // R17
    @(posedge hclk) disable iff (!hresetn)
    !state_reg.injected_external_trigger_enable |=> !injected_start)
    else $error("injected start while disabled");

  chk_timer_edge: assert property (  // R1
    @(posedge hclk) disable iff (!hresetn)
    (state_reg.regular_external_trigger_enable && state_reg.regular_trigger_select == 3'h4
     && $rose(reg_src[4])) |=> regular_start)
    else $error("code four edge gave no start");

  chk_code_five: assert property (  // R2
    @(posedge hclk) disable iff (!hresetn)
    (state_reg.regular_external_trigger_enable && state_reg.regular_trigger_select == 3'h5
     && $rose(reg_src[5])) |=> regular_start)
    else $error("code five edge gave no start");

  chk_sensor_only_one: assert property (  // R10
    @(posedge hclk) disable iff (!hresetn)
    internal_sensor_channel_enable |-> CONVERTER_INDEX == 1)
    else $error("sensor enable outside converter one");

  chk_sensor_write: assert property (  // R9
    @(posedge hclk) disable iff (!hresetn)
    (ctrl_wr_now && CONVERTER_INDEX == 1)
    |=> internal_sensor_channel_enable == $past(hwdata[23]))
    else $error("sensor enable not written");

  chk_select_write: assert property (  // R15
    @(posedge hclk) disable iff (!hresetn)
    ctrl_wr_now |=> state_reg.regular_trigger_select == $past(hwdata[19:17]))
    else $error("regular select not written");

  chk_high_reserved: assert property (  // R12
    @(posedge hclk) disable iff (!hresetn)
    (state_reg.dp_valid && !state_reg.dp_write && state_reg.dp_index == REG_SMP_HIGH)
    |-> hrdata[31:24] == 8'h00)
    else $error("reserved high bits not zero");

  chk_low_reserved: assert property (  // R13
    @(posedge hclk) disable iff (!hresetn)
    (state_reg.dp_valid && !state_reg.dp_write && state_reg.dp_index == REG_SMP_LOW)
    |-> hrdata[31:30] == 2'h0)
    else $error("reserved low bits not zero");

endmodule : adc_trigger_config

// ==== sim/timer_event_model.sv ====
// Purpose: Far-side timer and external-line event sources
// Assumes: Events are active-high levels that idle low
// Notes:   One source at a time, held a few cycles so only one rise is seen
`timescale 1ns/10ps
module timer_event_model (
  input  wire logic        hclk,
  input  wire logic        go,
  input  wire logic [4:0]  src,
  output logic      [31:0] events
);
  logic [2:0] hold_reg;

  // Level held past one cycle: a long level must still give a single start
  // One process owns both variables, so each has a single driver
  initial begin
    events   = '0;
    hold_reg = '0;
    forever begin
      @(posedge hclk);
      if (go) begin
        events   <= 32'h1 << src;
        hold_reg <= 3'h4;
      end else if (hold_reg != 3'h0) begin
        hold_reg <= hold_reg - 3'h1;
        if (hold_reg == 3'h1) events <= '0;
      end
    end
  end
endmodule : timer_event_model

// ==== sim/adc_trigger_config_tb_top.sv ====
// Purpose: Self-checking bench of the trigger and sample-time block
// Assumes: One AHB-Lite slave, converter one trigger table
// Notes:   Expected reads and starts queue up; a watcher compares them
`timescale 1ns/10ps
module adc_trigger_config_tb_top;
  logic        hclk, hresetn, hsel, hwrite, go, dph, sensor, hready, hresp, rstart, istart;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, events, r1, r2, ctl;
  logic [4:0]  src, chan;
  logic [9:0]  half;
  logic [2:0]  code;
  logic [31:0] rd_q[$];
  logic [1:0]  st_q[$];
  int          errors, total_checks, cycles, s, w;
  int          rtab[7] = '{0, 1, 2, 6, 14, 18, 30};
  int          itab[7] = '{4, 8, -1, 5, 13, 19, 31};
  logic [9:0]  hp[8] = '{10'h003, 10'h00f, 10'h01b, 10'h039, 10'h053, 10'h06f, 10'h08f, 10'h1df};

  adc_trigger_config #(.CONVERTER_INDEX(1)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata),
    .timer1_compare_event(events[3:0]), .timer1_trigger_output(events[4]),
    .timer2_compare_event(events[8:5]), .timer2_trigger_output(events[9]),
    .timer3_compare_event(events[13:10]), .timer3_trigger_output(events[14]),
    .timer4_compare_event(events[18:15]), .timer4_trigger_output(events[19]),
    .timer5_compare_event(events[23:20]), .timer5_trigger_output(events[24]),
    .timer8_compare_event(events[28:25]), .timer8_trigger_output(events[29]),
    .external_interrupt_line_11(events[30]), .external_interrupt_line_15(events[31]),
    .sample_channel(chan), .sample_half_periods(half), .regular_start(rstart),
    .injected_start(istart), .internal_sensor_channel_enable(sensor));
  timer_event_model i_events (.hclk(hclk), .go(go), .src(src), .events(events));

  // Free-running bus clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Single word transfer; for a read, d is the expected data
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    if (wr) hwdata <= d;
    else rd_q.push_back(d);
    dph    <= !wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    dph    <= 1'b0;
  endtask : bus

  // Negative source number means no event at all
  task automatic fire(input int n);
    @(posedge hclk);
    src <= n[4:0];
    go  <= (n >= 0);
    @(posedge hclk);
    go  <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask : fire

  // Watcher: read data and start pulses against the oldest note
  always @(posedge hclk) begin
    cycles++;
    if (dph && hready) chk(hrdata, rd_q.pop_front());
    if (dph && hready) chk({31'h0, hresp}, 32'h0);  // Response always OKAY
    if (rstart | istart)
      chk({30'h0, istart, rstart},
          (st_q.size() > 0) ? {30'h0, st_q.pop_front()} : 32'h0);
    if (cycles > 20000) begin
      errors++;
      report_and_stop();
    end
  end

  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, go, dph} = '0;
    {haddr, hwdata, htrans, src, chan} = '0;
    {errors, total_checks, cycles} = '0;
    void'($urandom(32'h8ebd5869));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, 12'h00c, 32'h0);
    bus(0, 12'h010, 32'h0);
    bus(0, 12'h008, 32'h0);
    bus(0, 12'h040, 32'h0);
    r1 = $urandom;
    r2 = $urandom;
    bus(1, 12'h00c, r1);
    bus(1, 12'h010, r2);
    bus(0, 12'h00c, r1 & 32'h00ff_ffff);
    bus(0, 12'h010, r2 & 32'h3fff_ffff);
    // Channels past the last one must give the shortest time
    for (int ch = 0; ch < 20; ch++) begin
      code = (ch > 17) ? 3'h0 : (ch < 10) ? r2[3*ch +: 3] : r1[3*(ch-10) +: 3];
      @(posedge hclk);
      chan <= ch[4:0];
      repeat (2) @(posedge hclk);
      #1 chk({22'h0, half}, {22'h0, hp[code]});
    end
    // Software starts, then the bit must read back cleared
    st_q.push_back(2'b01);
    bus(1, 12'h008, 32'h00de_0000);
    bus(0, 12'h008, 32'h009e_0000);
    chk({31'h0, sensor}, 32'h1);
    st_q.push_back(2'b10);
    bus(1, 12'h008, 32'h0020_f000);
    bus(0, 12'h008, 32'h0000_f000);
    chk({31'h0, sensor}, 32'h0);
    repeat (4) @(posedge hclk);
    // Trigger codes 0-6 of both groups: disabled, wrong source, then the selected one
    for (int g = 0; g < 2; g++) begin
      for (int c = 0; c < 7; c++) begin
        s   = g ? itab[c] : rtab[c];
        w   = g ? itab[(c+1)%7] : rtab[(c+1)%7];
        ctl = g ? (32'h8000 | (32'(c) << 12)) : (32'h0010_0000 | (32'(c) << 17));
        bus(1, 12'h008, ctl & 32'h000e_7000);
        fire(s);
        bus(1, 12'h008, ctl);
        fire(w);
        if (s >= 0) st_q.push_back(g ? 2'b10 : 2'b01);
        fire(s);
        chk(st_q.size(), 32'h0);
      end
    end
    report_and_stop();
  end
endmodule : adc_trigger_config_tb_top
